// ---- verilog/rbc_pkg.sv ----
// Purpose: Shared constants and types of the reset and security register bank
// Assumes: 20 MHz always-on core clock, APB with 32-bit data
// Notes:   Printed offsets are word indices; byte address is index times four
package rbc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned CLK_MHZ  = CLK_HZ / 1_000_000;
  localparam int unsigned DLY0_US  = 3000;
  localparam int unsigned DLY1_US  = 11000;
  localparam int unsigned DLY2_US  = 51000;
  localparam int unsigned DLY3_US  = 101000;
  localparam int unsigned DLY0_CYC = DLY0_US * CLK_MHZ;
  localparam int unsigned DLY1_CYC = DLY1_US * CLK_MHZ;
  localparam int unsigned DLY2_CYC = DLY2_US * CLK_MHZ;
  localparam int unsigned DLY3_CYC = DLY3_US * CLK_MHZ;
  localparam int unsigned CNT_W    = 21;

  // ==========================================================================
  // Bus geometry and register indices
  localparam int unsigned ADDR_W   = 18;
  localparam logic [15:0] RST_CTL_IDX = 16'h4006;
  localparam logic [15:0] LINK_IDX    = 16'h4007;
  localparam logic [15:0] KEY_IDX     = 16'h4008;
  localparam logic [15:0] SCR_IDX     = 16'h4009;
  localparam logic [15:0] PTR_IDX     = 16'h400C;
  localparam logic [15:0] WIN_IDX     = 16'h400D;

  // ==========================================================================
  // Field positions
  localparam int unsigned RC_RELOAD_BIT = 15;
  localparam int unsigned RC_SCOPE_BIT  = 10;
  localparam int unsigned RC_AUX_BIT    = 6;
  localparam int unsigned RC_MASK_BIT   = 5;
  localparam int unsigned RC_RSTLVL_BIT = 4;
  localparam int unsigned RC_DLY_LSB    = 0;
  localparam int unsigned LC_STEP_BIT   = 2;

  // ==========================================================================
  // Reset values and masks
  localparam logic [15:0] RST_CTL_RST   = 16'h8473;
  localparam logic [15:0] RST_CTL_WMASK = 16'h8473;
  localparam logic [15:0] SCOPE_MASK    = 16'h0400;
  localparam logic [15:0] LINK_RST      = 16'h0004;
  localparam logic [15:0] LINK_WMASK    = 16'h0004;
  localparam logic [15:0] KEY_RST       = 16'h0000;
  localparam logic [15:0] SCR_RST       = 16'h0000;
  localparam logic [15:0] PTR_RST       = 16'h4006;
  localparam logic [15:0] UNLOCK_KEY    = 16'h9716;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } rbc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rbc_apb_rsp_t;

  typedef struct packed {
    logic aux_lvl;
    logic ext_mask;
    logic rst_lvl;
  } rbc_sleep_cfg_t;

  // ==========================================================================
  // Module state
  typedef struct packed {
    logic [15:0] rst_ctl;
    logic [15:0] link_ctl;
    logic [15:0] key;
    logic [15:0] scratch;
    logic [15:0] ptr;
    logic [31:0] rdata;
    logic        slverr;
    logic        reload;
  } rbc_state_t;

  localparam rbc_state_t ST_RST = '{rst_ctl: RST_CTL_RST, link_ctl: LINK_RST,
                                    key: KEY_RST, scratch: SCR_RST,
                                    ptr: PTR_RST, rdata: 32'h0000_0000,
                                    slverr: 1'b0, reload: 1'b0};

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } rbc_tmr_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic rst_n;
    logic aux;
    logic ext_req;
  } rbc_slp_state_t;

endpackage

// ---- verilog/rbc_release_timer.sv ----
// Purpose: Holds reset asserted for the chosen delay after WAKE
// Assumes: start_i is a one-cycle pulse from the core clock domain
// Notes:   A new start reloads the count, so the latest sequence wins
`timescale 1ns/1ps
module rbc_release_timer #(
  parameter int unsigned D0_CYC = rbc_pkg::DLY0_CYC,
  parameter int unsigned D1_CYC = rbc_pkg::DLY1_CYC,
  parameter int unsigned D2_CYC = rbc_pkg::DLY2_CYC,
  parameter int unsigned D3_CYC = rbc_pkg::DLY3_CYC
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [1:0] sel_i,
  output logic            hold_o
);
  import rbc_pkg::*;

  rbc_tmr_state_t q;
  rbc_tmr_state_t d;
  logic [CNT_W-1:0] load;

  // ==========================================================================
  // Countdown
  always_comb begin
    case (sel_i)
      2'b00:   load = CNT_W'(D0_CYC);
      2'b01:   load = CNT_W'(D1_CYC);
      2'b10:   load = CNT_W'(D2_CYC);
      default: load = CNT_W'(D3_CYC);
    endcase
    d = q;
    if (start_i) begin
      d.cnt = load;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign hold_o = (q.cnt != '0);

  // ==========================================================================
  // Checks
  delay_load_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && start_i |=> hold_o && q.cnt == $past(load))
    else $error("release delay not loaded");

  delay_step_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && !start_i && hold_o |=> q.cnt == $past(q.cnt) - CNT_W'(1))
    else $error("release delay not counting down");

endmodule

// ---- verilog/rbc_sleep_pins.sv ----
// Purpose: Drives reset pins in SLEEP and filters the external reset pin
// Assumes: ext_reset_n_i is asynchronous to the core clock
// Notes:   Outputs are registered: pin drives lag their causes by one cycle, the external request lags its pin by three
`timescale 1ns/1ps
module rbc_sleep_pins (
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    ce_i,
  // Control
  input  wire logic                    sleep_i,
  input  wire logic                    hold_i,
  input  wire rbc_pkg::rbc_sleep_cfg_t cfg_i,
  // Pins
  input  wire logic                    ext_reset_n_i,
  output logic                         reset_n_o,
  output logic                         aux_reset_o,
  output logic                         ext_reset_req_o
);
  import rbc_pkg::*;

  rbc_slp_state_t q;
  rbc_slp_state_t d;

  // ==========================================================================
  // Pin logic
  always_comb begin
    d = q;
    d.sync1   = ext_reset_n_i;
    d.sync2   = q.sync1;
    d.rst_n   = !(hold_i || (sleep_i && cfg_i.rst_lvl));
    d.aux     = hold_i || (sleep_i && cfg_i.aux_lvl);
    d.ext_req = !q.sync2 && !(sleep_i && cfg_i.ext_mask);
  end

  // Pin released high at reset so the synchroniser starts idle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, rst_n: 1'b0, aux: 1'b1, ext_req: 1'b0};
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign reset_n_o       = q.rst_n;
  assign aux_reset_o     = q.aux;
  assign ext_reset_req_o = q.ext_req;

  // ==========================================================================
  // Checks
  aux_sleep_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && sleep_i && !hold_i |=> aux_reset_o == $past(cfg_i.aux_lvl))
    else $error("aux reset wrong in sleep");

  ext_mask_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && sleep_i && cfg_i.ext_mask |=> !ext_reset_req_o)
    else $error("external reset not masked in sleep");

  rst_sleep_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && sleep_i && !hold_i |=> reset_n_o == !$past(cfg_i.rst_lvl))
    else $error("reset pin wrong in sleep");

endmodule

// ---- verilog/rbc_regs.sv ----
// Purpose: Reset behaviour, key, link and scratch registers behind APB
// Assumes: Power-state strobes come from logic on the core clock
// Notes:   Zero-wait APB slave; read data captured in the setup cycle
//
// Summary of operation
// - Reload boot data on ON if enabled
// - Soft reset clears map unless scope set
// - Aux reset level in sleep from bit
// - Ignore external reset in sleep if masked
// - Reset pin low in sleep if bit set
// - Hold reset for chosen delay after wake
// - Key 9716h unlocks protected reset fields
// - Window pointer steps when auto-increment set
// - Free scratch word kept through backup
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module rbc_regs #(
  parameter int unsigned D0_CYC = rbc_pkg::DLY0_CYC,
  parameter int unsigned D1_CYC = rbc_pkg::DLY1_CYC,
  parameter int unsigned D2_CYC = rbc_pkg::DLY2_CYC,
  parameter int unsigned D3_CYC = rbc_pkg::DLY3_CYC
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  // APB slave
  input  wire rbc_pkg::rbc_apb_req_t apb_req_i,
  output rbc_pkg::rbc_apb_rsp_t      apb_rsp_o,
  // Power-state events
  input  wire logic                  sleep_i,
  input  wire logic                  on_transition_i,
  input  wire logic                  on_wake_done_i,
  input  wire logic                  soft_reset_i,
  // Pins
  input  wire logic                  ext_reset_n_i,
  output logic                       reset_n_o,
  output logic                       aux_reset_o,
  output logic                       ext_reset_req_o,
  // Core controls
  output logic                       boot_reload_o,
  output logic                       address_step_enable_o
);
  import rbc_pkg::*;

  rbc_state_t     q;
  rbc_state_t     d;
  rbc_sleep_cfg_t slp_cfg;
  logic [15:0]    idx;
  logic [15:0]    eff;
  logic           win;
  logic           setup;
  logic           access;
  logic           unlocked;
  logic           step_en;
  logic           hold;
  logic [16:0]    rd;

  // ==========================================================================
  // Decode
  // Bit 16 of the result marks a mapped index; clear means refuse
  function automatic logic [16:0] read_reg(rbc_state_t s, logic [15:0] i);
    case (i)
      RST_CTL_IDX: read_reg = {1'b1, s.rst_ctl};
      LINK_IDX:    read_reg = {1'b1, s.link_ctl};
      KEY_IDX:     read_reg = {1'b1, s.key};
      SCR_IDX:     read_reg = {1'b1, s.scratch};
      PTR_IDX:     read_reg = {1'b1, s.ptr};
      default:     read_reg = {1'b0, 16'h0000};
    endcase
  endfunction

  assign idx      = apb_req_i.paddr[ADDR_W-1:2];
  assign win      = (idx == WIN_IDX);
  assign eff      = win ? q.ptr : idx;
  assign setup    = apb_req_i.psel && !apb_req_i.penable;
  assign access   = apb_req_i.psel && apb_req_i.penable;
  assign unlocked = (q.key == UNLOCK_KEY);
  assign step_en  = q.link_ctl[LC_STEP_BIT];
  assign rd       = read_reg(q, eff);

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    // Recomputed each cycle, so the pulse lasts exactly as long as the strobe is held
    d.reload = on_transition_i && q.rst_ctl[RC_RELOAD_BIT];
    if (setup) begin
      d.rdata  = {16'h0000, rd[15:0]};
      d.slverr = !rd[16] || (apb_req_i.paddr[1:0] != 2'b00);
    end
    // Window access moves the pointer if stepping is on; a pointer write below overrides it
    if (access && win && !q.slverr && step_en) begin
      d.ptr = q.ptr + 16'h0001;
    end
    if (access && apb_req_i.pwrite && !q.slverr) begin
      case (eff)
        RST_CTL_IDX: begin
          if (unlocked) begin
            d.rst_ctl = apb_req_i.pwdata[15:0] & RST_CTL_WMASK;
          end else begin
            // Scope bit stays writable without the key
            d.rst_ctl = (q.rst_ctl & ~SCOPE_MASK) |
                        (apb_req_i.pwdata[15:0] & SCOPE_MASK);
          end
        end
        LINK_IDX: d.link_ctl = apb_req_i.pwdata[15:0] & LINK_WMASK;
        KEY_IDX:  d.key      = apb_req_i.pwdata[15:0];
        SCR_IDX:  d.scratch  = apb_req_i.pwdata[15:0];
        PTR_IDX:  d.ptr      = apb_req_i.pwdata[15:0];
        default:  d.ptr      = d.ptr;
      endcase
    end
    // Soft reset beats a same-cycle bus write; scratch lives on always-on
    if (soft_reset_i && !q.rst_ctl[RC_SCOPE_BIT]) begin
      d.rst_ctl  = RST_CTL_RST;
      d.link_ctl = LINK_RST;
      d.key      = KEY_RST;
      d.ptr      = PTR_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= ST_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // Ready follows the enable so a frozen block never finishes a transfer
  assign apb_rsp_o = '{prdata:  q.rdata,
                       pready:  ce_i,
                       pslverr: q.slverr};
  assign boot_reload_o     = q.reload;
  assign address_step_enable_o = step_en;

  // Sleep configuration handed on as one carrier
  assign slp_cfg = '{aux_lvl:  q.rst_ctl[RC_AUX_BIT],
                     ext_mask: q.rst_ctl[RC_MASK_BIT],
                     rst_lvl:  q.rst_ctl[RC_RSTLVL_BIT]};

  // ==========================================================================
  // Reset release and pins
  // Every wake strobe restarts the delay; the latest one wins
  rbc_release_timer #(
    .D0_CYC (D0_CYC),
    .D1_CYC (D1_CYC),
    .D2_CYC (D2_CYC),
    .D3_CYC (D3_CYC)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .start_i    (on_wake_done_i),
    .sel_i      (q.rst_ctl[RC_DLY_LSB +: 2]),
    .hold_o     (hold)
  );

  rbc_sleep_pins u_pins (
    .core_clk_i      (core_clk_i),
    .resetn_i        (resetn_i),
    .ce_i            (ce_i),
    .sleep_i         (sleep_i),
    .hold_i          (hold),
    .cfg_i           (slp_cfg),
    .ext_reset_n_i   (ext_reset_n_i),
    .reset_n_o       (reset_n_o),
    .aux_reset_o     (aux_reset_o),
    .ext_reset_req_o (ext_reset_req_o)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  reload_pulse_a: assert property (
    ce_i && on_transition_i |=> boot_reload_o == $past(q.rst_ctl[15]))
    else $error("boot reload does not follow enable");

  reload_none_a: assert property (
    ce_i && !on_transition_i |=> !boot_reload_o)
    else $error("boot reload without ON transition");

  soft_clear_a: assert property (
    ce_i && soft_reset_i && !q.rst_ctl[10]
    |=> q.key == 16'h0000 && q.rst_ctl == 16'h8473 && q.link_ctl == 16'h0004)
    else $error("soft reset did not restore defaults");

  soft_keep_a: assert property (
    ce_i && soft_reset_i && q.rst_ctl[10] && !access
    |=> $stable(q.rst_ctl) && $stable(q.key) && $stable(q.link_ctl))
    else $error("soft reset touched map with scope set");

  scratch_keep_a: assert property (
    ce_i && soft_reset_i && !access |=> $stable(q.scratch))
    else $error("scratch lost on soft reset");

  hold_pin_a: assert property (
    ce_i && hold |=> !reset_n_o)
    else $error("reset released during delay");

  key_lock_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4006
    && !q.slverr && q.key != 16'h9716 && !soft_reset_i
    |=> (q.rst_ctl & 16'hFBFF) == $past(q.rst_ctl & 16'hFBFF))
    else $error("protected field changed while locked");

  key_open_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4006
    && !q.slverr && q.key == 16'h9716 && !soft_reset_i
    |=> q.rst_ctl == ($past(apb_req_i.pwdata[15:0]) & 16'h8473))
    else $error("unlocked write not applied");

  step_on_a: assert property (
    ce_i && access && win && !q.slverr && q.link_ctl[2]
    && !(apb_req_i.pwrite && q.ptr == 16'h400C)
    && !(soft_reset_i && !q.rst_ctl[10])
    |=> q.ptr == $past(q.ptr) + 16'h0001)
    else $error("pointer did not step");

  step_off_a: assert property (
    ce_i && access && win && !q.link_ctl[2]
    && !(apb_req_i.pwrite && q.ptr == 16'h400C)
    && !(soft_reset_i && !q.rst_ctl[10]) |=> $stable(q.ptr))
    else $error("pointer moved with stepping off");

  scratch_wr_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4009 && !q.slverr
    |=> q.scratch == $past(apb_req_i.pwdata[15:0]))
    else $error("scratch write lost");

  bad_addr_a: assert property (
    ce_i && setup && !rd[16] |=> apb_rsp_o.pslverr)
    else $error("unmapped access not flagged");

  unaligned_a: assert property (
    ce_i && setup && apb_req_i.paddr[1:0] != 2'b00 |=> apb_rsp_o.pslverr)
    else $error("unaligned access not flagged");

  rdata_upper_a: assert property (
    ce_i && setup |=> apb_rsp_o.prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // Freeze must hold every register of the bank state q, not just the bus path
  state_freeze_a: assert property (
    !ce_i |=> $stable(q))
    else $error("state moved while clock enable low");

  aux_hold_a: assert property (
    ce_i && hold |=> aux_reset_o)
    else $error("aux reset released during delay");

  sleep_pin_a: assert property (
    ce_i && sleep_i && !hold |=> reset_n_o == !$past(q.rst_ctl[4]))
    else $error("reset pin wrong in sleep");

  // Error and soft reset paths excluded; both have their own checks
  key_wr_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4008 && !q.slverr
    && !(soft_reset_i && !q.rst_ctl[10])
    |=> q.key == $past(apb_req_i.pwdata[15:0]))
    else $error("key write lost");

  scope_wr_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4006 && !q.slverr
    && !soft_reset_i |=> q.rst_ctl[10] == $past(apb_req_i.pwdata[10]))
    else $error("scope bit not writable");

  link_wr_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4007 && !q.slverr
    && !(soft_reset_i && !q.rst_ctl[10])
    |=> q.link_ctl == ($past(apb_req_i.pwdata[15:0]) & 16'h0004))
    else $error("link control write lost");

  ptr_wr_a: assert property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h400C && !q.slverr
    && !(soft_reset_i && !q.rst_ctl[10])
    |=> q.ptr == $past(apb_req_i.pwdata[15:0]))
    else $error("pointer write lost");

  scratch_rd_a: assert property (
    ce_i && setup && eff == 16'h4009
    |=> apb_rsp_o.prdata == {16'h0000, $past(q.scratch)})
    else $error("scratch read wrong");

  soft_ptr_a: assert property (
    ce_i && soft_reset_i && !q.rst_ctl[10] |=> q.ptr == 16'h4006)
    else $error("soft reset did not restore pointer");

  err_nowrite_a: assert property (
    ce_i && access && apb_req_i.pwrite && q.slverr && !soft_reset_i
    |=> $stable(q.rst_ctl) && $stable(q.key) && $stable(q.scratch)
        && $stable(q.link_ctl) && $stable(q.ptr))
    else $error("refused write changed a register");

  unlock_c: cover property (
    ce_i && access && apb_req_i.pwrite && eff == 16'h4008
    && apb_req_i.pwdata[15:0] == 16'h9716);
  wake_c: cover property (hold ##1 !hold);
  window_c: cover property (ce_i && access && win && q.link_ctl[2]);
  soft_c: cover property (ce_i && soft_reset_i && !q.rst_ctl[10]);
  reload_c: cover property (boot_reload_o);

endmodule

// ---- bench/rbc_host_model.sv ----
// Purpose: Host processor model, APB master of the register bank
// Assumes: Caller enters a transfer right after a rising clock edge
// Notes:   Waits up to 16 cycles for pready, then flags a timeout
`timescale 1ns/1ps
module rbc_host_model (
  // Clock
  input  wire logic                  core_clk_i,
  // APB master
  output rbc_pkg::rbc_apb_req_t      apb_req_o,
  input  wire rbc_pkg::rbc_apb_rsp_t apb_rsp_i
);
  import rbc_pkg::*;

  // ==========================================================================
  // Bus cycle
  initial apb_req_o = '0;

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err, output logic tmo);
    tmo               = 1'b1;
    rdata             = 32'h0000_0000;
    err               = 1'b0;
    apb_req_o.psel    <= 1'b1;
    apb_req_o.penable <= 1'b0;
    apb_req_o.pwrite  <= wr;
    apb_req_o.paddr   <= addr;
    apb_req_o.pwdata  <= wdata;
    @(posedge core_clk_i);
    apb_req_o.penable <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      @(posedge core_clk_i);
      if (apb_rsp_i.pready === 1'b1) begin
        rdata = apb_rsp_i.prdata;
        err   = apb_rsp_i.pslverr;
        tmo   = 1'b0;
        break;
      end
    end
    // Stale values inverted so an idle bus never looks like the last one
    apb_req_o.psel    <= 1'b0;
    apb_req_o.penable <= 1'b0;
    apb_req_o.paddr   <= ~addr;
    apb_req_o.pwdata  <= ~wdata;
    @(posedge core_clk_i);
  endtask
endmodule

// ---- bench/rbc_regs_bench.sv ----
// Purpose: Self-checking bench of the reset and security register bank
// Assumes: Release delays shortened to a few cycles
// Notes:   Clock enable dropped once to check that a strobe is ignored
`timescale 1ns/1ps
module rbc_regs_bench;
  import rbc_pkg::*;

  // ==========================================================================
  // Design and host
  localparam int unsigned DC [4] = '{5, 7, 9, 11};
  localparam logic [17:0] A_RC   = 18'h1_0018;
  localparam logic [17:0] A_LINK = 18'h1_001C;
  localparam logic [17:0] A_KEY  = 18'h1_0020;
  localparam logic [17:0] A_SCR  = 18'h1_0024;
  localparam logic [17:0] A_PTR  = 18'h1_0030;
  localparam logic [17:0] A_WIN  = 18'h1_0034;

  logic         core_clk, resetn, ce, sleep, on_tr, wake_done, soft_rst;
  logic         ext_rst_n, rst_n, aux_rst, ext_req, reload, step_en;
  rbc_apb_req_t req;
  rbc_apb_rsp_t rsp;
  logic [31:0]  rd;
  logic         err, tmo;
  int           num_errors, checks, len;

  always #25 core_clk = ~core_clk;

  rbc_regs #(.D0_CYC(DC[0]), .D1_CYC(DC[1]), .D2_CYC(DC[2]),
             .D3_CYC(DC[3])) dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .ce_i(ce),
    .apb_req_i(req), .apb_rsp_o(rsp), .sleep_i(sleep),
    .on_transition_i(on_tr), .on_wake_done_i(wake_done),
    .soft_reset_i(soft_rst), .ext_reset_n_i(ext_rst_n),
    .reset_n_o(rst_n), .aux_reset_o(aux_rst), .ext_reset_req_o(ext_req),
    .boot_reload_o(reload), .address_step_enable_o(step_en));

  rbc_host_model host (.core_clk_i(core_clk), .apb_req_o(req),
                       .apb_rsp_i(rsp));

  // ==========================================================================
  // Tasks
  task automatic stop_test();
    $display("mismatches %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [31:0] d);
    host.xfer(wr, a, d, rd, err, tmo);
    if (tmo) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input string what, input logic [17:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
    check({what, " error"}, 32'(err), 32'h0000_0000);
  endtask

  // Pulse 0 ON, 1 wake done, 2 soft reset; returns after the sampling edge
  task automatic ev(input int k);
    on_tr     <= (k == 0);
    wake_done <= (k == 1);
    soft_rst  <= (k == 2);
    @(posedge core_clk);
    {on_tr, wake_done, soft_rst} <= 3'b000;
  endtask

  task automatic reload_case(input logic [15:0] rc, input logic exp);
    bus(1'b1, A_RC, {16'h0000, rc});
    ev(0);
    #1 check("boot reload", 32'(reload), 32'(exp));
    @(posedge core_clk);
    #1 check("boot reload end", 32'(reload), 32'h0000_0000);
    @(posedge core_clk);
  endtask

  task automatic delay_case(input int k);
    bus(1'b1, A_RC, 32'h0000_0400 | k);
    ev(1);
    len = 0;
    for (int n = 0; n < 200; n++) begin
      @(posedge core_clk);
      #1;
      if (rst_n === 1'b0) begin
        len++;
      end else if (len > 0) begin
        break;
      end
    end
    check("release delay", len, DC[k]);
    @(posedge core_clk);
  endtask

  task automatic sleep_case(input logic [15:0] rc);
    bus(1'b1, A_RC, {16'h0000, rc});
    sleep     <= 1'b1;
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 check("reset pin", 32'(rst_n), 32'(!rc[4]));
    check("aux reset", 32'(aux_rst), 32'(rc[6]));
    check("ext request", 32'(ext_req), 32'(!rc[5]));
    @(posedge core_clk);
    sleep <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 check("ext request awake", 32'(ext_req), 32'h0000_0001);
    @(posedge core_clk);
    ext_rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic window_case(input logic step);
    bus(1'b1, A_LINK, {29'h0, step, 2'b00});
    check("step enable", 32'(step_en), 32'(step));
    bus(1'b1, A_PTR, 32'h0000_4006);
    rd_chk("window first", A_WIN, 32'h0000_8473);
    rd_chk("window next", A_WIN,
           step ? 32'h0000_0004 : 32'h0000_8473);
    rd_chk("pointer", A_PTR,
           step ? 32'h0000_4008 : 32'h0000_4006);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {num_errors, checks, len} = '0;
    {core_clk, resetn, sleep, on_tr, wake_done, soft_rst} = '0;
    ce        = 1'b1;
    ext_rst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd_chk("control reset", A_RC, 32'h0000_8473);
    rd_chk("link reset", A_LINK, 32'h0000_0004);
    rd_chk("key reset", A_KEY, 32'h0000_0000);
    rd_chk("scratch reset", A_SCR, 32'h0000_0000);
    bus(1'b1, A_RC, 32'h0000_0000);
    rd_chk("locked control", A_RC, 32'h0000_8073);
    bus(1'b1, A_KEY, {16'h0000, UNLOCK_KEY});
    rd_chk("key", A_KEY, 32'h0000_9716);
    bus(1'b1, A_RC, 32'h0000_0000);
    rd_chk("open control", A_RC, 32'h0000_0000);
    bus(1'b1, A_RC, 32'hFFFF_FFFF);
    rd_chk("control mask", A_RC, 32'h0000_8473);
    reload_case(16'h8473, 1'b1);
    ce <= 1'b0;
    ev(0);
    ce <= 1'b1;
    #1 check("frozen reload", 32'(reload), 32'h0000_0000);
    @(posedge core_clk);
    reload_case(16'h0473, 1'b0);
    for (int k = 0; k < 4; k++) begin
      delay_case(k);
    end
    sleep_case(16'h0470);
    sleep_case(16'h0400);
    bus(1'b1, A_KEY, 32'h0000_1234);
    bus(1'b1, A_RC, 32'hFFFF_FFFF);
    rd_chk("relocked control", A_RC, 32'h0000_0400);
    bus(1'b1, A_SCR, 32'hDEAD_5A5A);
    rd_chk("scratch", A_SCR, 32'h0000_5A5A);
    host.xfer(1'b0, 18'h1_0028, 32'h0000_0000, rd, err, tmo);
    check("unmapped error", 32'(err), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    ev(2);
    rd_chk("control kept", A_RC, 32'h0000_0400);
    rd_chk("key kept", A_KEY, 32'h0000_1234);
    bus(1'b1, A_RC, 32'h0000_0000);
    bus(1'b1, A_LINK, 32'h0000_0000);
    ev(2);
    rd_chk("control cleared", A_RC, 32'h0000_8473);
    rd_chk("key cleared", A_KEY, 32'h0000_0000);
    rd_chk("link cleared", A_LINK, 32'h0000_0004);
    rd_chk("scratch retained", A_SCR, 32'h0000_5A5A);
    window_case(1'b1);
    window_case(1'b0);
    stop_test();
  end
endmodule
